// File: dsc_regs.svh
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// register byte offsets
`define DSC_REG_STATUS     12'h000
`define DSC_REG_CTRL       12'h004
`define DSC_REG_IRQ_STAT   12'h008
`define DSC_REG_IRQ_CLR    12'h00c
`define DSC_REG_IRQ_EN     12'h010
`define DSC_REG_LAST_DIGIT 12'h014

// control fields
`define DSC_CTRL_DEC_EN    0
`define DSC_CTRL_ALL_EN    1
`define DSC_CTRL_RESET     2'h3

// interrupt event bits
`define DSC_IRQ_MATCH      0
`define DSC_IRQ_ALLCALL    1
`define DSC_IRQ_TIMEOUT    2
`define DSC_IRQ_ANSWER     3
`define DSC_IRQ_CLEARED    4
`define DSC_IRQ_W          5

// tone codes
`define DSC_CODE_STAR      4'hb
`define DSC_CODE_HASH      4'hc

// timing
`define DSC_CLK_KHZ        10000
`define DSC_RING_MS        19000
`define DSC_ALLCALL_MS     4000
`define DSC_RING_CYCLES    (`DSC_RING_MS * `DSC_CLK_KHZ)
`define DSC_ALLCALL_CYCLES (`DSC_ALLCALL_MS * `DSC_CLK_KHZ)

`endif

// File: dsc_pkg.sv
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_COLLECT = 2'b01,
        DSC_ALERT   = 2'b10
    } dsc_state_e;

    typedef logic [3:0] dsc_digit_t;
endpackage

// File: dsc_sync.sv
`timescale 1ns/1ps
module dsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dsc_sync_s;

    dsc_sync_s s_r;
    dsc_sync_s s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = async_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stable;
endmodule

// File: dsc_timer.sv
`timescale 1ns/1ps
module dsc_timer #(
    parameter int WIDTH  = 28,
    parameter int CYCLES = 16
) (
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic start_in,
    input  wire logic clear_in,
    output logic      done_out
);
    typedef struct packed {
        logic             run;
        logic             done;
        logic [WIDTH-1:0] cnt;
    } dsc_timer_s;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES - 1);

    dsc_timer_s t_r;
    dsc_timer_s t_nxt;

    always_comb begin
        t_nxt      = t_r;
        t_nxt.done = 1'b0;
        if (clear_in) begin
            t_nxt.run = 1'b0;
            t_nxt.cnt = '0;
        end else if (start_in) begin
            t_nxt.run = 1'b1;
            t_nxt.cnt = '0;
        end else if (t_r.run) begin
            if (t_r.cnt == LAST) begin
                t_nxt.run  = 1'b0;
                t_nxt.done = 1'b1;
            end else begin
                t_nxt.cnt = t_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign done_out = t_r.done;
endmodule

// File: dsc_decoder.sv
// How it works
// R01: address length comes from a one-hot selector of one to four digits
// R02: four 4-bit selectors hold expected address digits one to four
// R03: digit codes: 1-9 binary, 0 is ten, star 11, hash 12, A-C 13-15, D 0
// R04: only the own address starts a call alert
// R05: receive alert relay is on exactly while alerting
// R06: transmit keying relay follows the off-hook state
// R07: off-hook lights the off-hook indicator and mutes the speaker
// R08: alert stops on answer or after the 19 second ring period
// R09: ringback tone is sent while ringing after a normal address call
// R10: star held about four seconds is an all-call alerting every station
// R11: the all-call originator gets no ringback and no alert
// R12: hash discards collected digits and restarts at digit one
// R13: incoming call lights alert indicator, alert tone at fixed loudness
// R14: audible alert tone only while on-hook
// R15: received star matches any digit in its position, count must match
// R16: a plugged headset means permanently off-hook
// R17: compare only after the configured digit count, drop on mismatch
// R18: alert holds until ring timeout or off-hook, then back to collecting
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_decoder #(
    parameter int RING_CYCLES    = `DSC_RING_CYCLES,
    parameter int ALLCALL_CYCLES = `DSC_ALLCALL_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        tone_valid_in,
    input  wire logic [3:0]  tone_code_in,
    input  wire logic [3:0]  address_length_select_in,
    input  wire logic [3:0]  first_digit_select_in,
    input  wire logic [3:0]  second_digit_select_in,
    input  wire logic [3:0]  third_digit_select_in,
    input  wire logic [3:0]  fourth_digit_select_in,
    input  wire logic        hook_off_in,
    input  wire logic        headset_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             off_hook_keying_out,
    output logic             call_alert_out,
    output logic             off_hook_led_out,
    output logic             speaker_mute_out,
    output logic             alert_led_out,
    output logic             alert_tone_out,
    output logic             ringback_out,
    output logic             irq_out
);
    //////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int PIN_W = 27;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic             tone_s;
    logic [3:0]       code_s;
    logic [3:0]       len_sel_s;
    logic [15:0]      addr_s;
    logic             off_hook_s;

    assign pins_raw = {tone_valid_in, tone_code_in, address_length_select_in,
                       fourth_digit_select_in, third_digit_select_in,
                       second_digit_select_in, first_digit_select_in,
                       hook_off_in, headset_in};

    dsc_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (pins_raw),
        .sync_out   (pins_s)
    );

    assign tone_s     = pins_s[26];
    assign code_s     = pins_s[25:22];
    assign len_sel_s  = pins_s[21:18];
    assign addr_s     = pins_s[17:2];
    assign off_hook_s = pins_s[1] | pins_s[0]; // [R16]

    //////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        dsc_pkg::dsc_state_e        st;
        logic                       tone_prev;
        dsc_pkg::dsc_digit_t        cur_code;
        logic                       long_star;
        logic [2:0]                 dig_cnt;
        logic [3:0][3:0]            digs;
        logic                       all_call;
        dsc_pkg::dsc_digit_t        last_digit;
        logic [1:0]                 ctrl;
        logic [`DSC_IRQ_W-1:0]      irq_stat;
        logic [`DSC_IRQ_W-1:0]      irq_en;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       slverr;
        logic                       keying;
        logic                       alert_relay;
        logic                       off_led;
        logic                       mute;
        logic                       alert_led;
        logic                       alert_tone;
        logic                       ringback;
        logic                       irq;
    } dsc_dec_s;

    dsc_dec_s r_r;
    dsc_dec_s r_nxt;

    logic ring_start;
    logic ring_clear;
    logic ring_done;
    logic star_start;
    logic star_clear;
    logic star_done;

    //////////////////////////////////////////////////////////////////////
    // timers
    localparam int RING_W = $clog2(RING_CYCLES + 1);
    localparam int STAR_W = $clog2(ALLCALL_CYCLES + 1);

    dsc_timer #(
        .WIDTH  (RING_W),
        .CYCLES (RING_CYCLES)
    ) u_ring (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (ring_start),
        .clear_in   (ring_clear),
        .done_out   (ring_done)
    );

    dsc_timer #(
        .WIDTH  (STAR_W),
        .CYCLES (ALLCALL_CYCLES)
    ) u_star (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (star_start),
        .clear_in   (star_clear),
        .done_out   (star_done)
    );

    //////////////////////////////////////////////////////////////////////
    // address compare helpers
    logic       tone_rise;
    logic       tone_fall;
    logic [2:0] len;
    logic       len_ok;
    logic [3:0] dig_hit;
    logic       apb_acc;
    logic       apb_wr;
    logic       apb_rd;

    assign tone_rise = tone_s & ~r_r.tone_prev;
    assign tone_fall = ~tone_s & r_r.tone_prev;

    always_comb begin
        len    = 3'd0;
        len_ok = 1'b1;
        unique case (len_sel_s) // [R01]
            4'h1:    len = 3'd1;
            4'h2:    len = 3'd2;
            4'h4:    len = 3'd3;
            4'h8:    len = 3'd4;
            default: len_ok = 1'b0;
        endcase
    end

    // per-position match, star is a wildcard
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            logic [3:0] rx;
            assign rx = (gi == int'(r_r.dig_cnt)) ? r_r.cur_code : r_r.digs[gi];
            assign dig_hit[gi] = (gi >= int'(len)) ||
                                 (rx == `DSC_CODE_STAR) || // [R15]
                                 (rx == addr_s[gi*4 +: 4]); // [R02] [R03]
        end
    endgenerate

    assign apb_acc = psel & penable & r_r.ready;
    assign apb_wr  = apb_acc & pwrite;
    assign apb_rd  = apb_acc & ~pwrite;

    //////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [`DSC_IRQ_W-1:0] ev;
        logic [`DSC_IRQ_W-1:0] clr;
        logic                  enter_alert;
        logic                  dec_en;
        logic                  alerting;
        r_nxt       = r_r;
        ev          = '0;
        clr         = '0;
        enter_alert = 1'b0;
        dec_en      = r_r.ctrl[`DSC_CTRL_DEC_EN];
        alerting    = 1'b0;
        ring_start  = 1'b0;
        ring_clear  = 1'b0;
        star_start  = 1'b0;
        star_clear  = 1'b0;

        r_nxt.tone_prev = tone_s;
        // latest code while the tone stands, rides out skew between synchronisers
        if (tone_s) begin
            r_nxt.cur_code = code_s;
        end
        if (tone_rise) begin
            r_nxt.long_star = 1'b0;
            star_start      = (code_s == `DSC_CODE_STAR);
        end
        if (!tone_s) begin
            star_clear = 1'b1;
        end

        unique case (r_r.st)
            dsc_pkg::DSC_COLLECT: begin
                if (off_hook_s || !dec_en || !len_ok) begin
                    r_nxt.dig_cnt = 3'd0;
                    star_clear    = 1'b1; // [R11]
                end else if (star_done && r_r.ctrl[`DSC_CTRL_ALL_EN]) begin
                    r_nxt.long_star = 1'b1;
                    r_nxt.all_call  = 1'b1; // [R10]
                    r_nxt.dig_cnt   = 3'd0;
                    enter_alert     = 1'b1;
                    ev[`DSC_IRQ_ALLCALL] = 1'b1;
                end else if (tone_fall && !r_r.long_star) begin
                    r_nxt.last_digit = r_r.cur_code;
                    if (r_r.cur_code == `DSC_CODE_HASH) begin
                        r_nxt.dig_cnt = 3'd0; // [R12]
                        ev[`DSC_IRQ_CLEARED] = 1'b1;
                    end else begin
                        r_nxt.digs[r_r.dig_cnt[1:0]] = r_r.cur_code;
                        if (r_r.dig_cnt + 3'd1 == len) begin
                            r_nxt.dig_cnt = 3'd0; // [R17]
                            if (&dig_hit) begin
                                r_nxt.all_call = 1'b0;
                                enter_alert    = 1'b1; // [R04]
                                ev[`DSC_IRQ_MATCH] = 1'b1;
                            end
                        end else begin
                            r_nxt.dig_cnt = r_r.dig_cnt + 3'd1;
                        end
                    end
                end
                if (enter_alert) begin
                    r_nxt.st   = dsc_pkg::DSC_ALERT;
                    ring_start = 1'b1;
                end
            end
            dsc_pkg::DSC_ALERT: begin
                if (off_hook_s) begin
                    r_nxt.st   = dsc_pkg::DSC_COLLECT; // [R08] [R18]
                    ring_clear = 1'b1;
                    ev[`DSC_IRQ_ANSWER] = 1'b1;
                end else if (ring_done) begin
                    r_nxt.st = dsc_pkg::DSC_COLLECT; // [R08] [R18]
                    ev[`DSC_IRQ_TIMEOUT] = 1'b1;
                end
            end
        endcase

        // outputs, all registered
        r_nxt.keying      = off_hook_s; // [R06]
        r_nxt.off_led     = off_hook_s; // [R07]
        r_nxt.mute        = off_hook_s; // [R07]
        alerting          = (r_nxt.st == dsc_pkg::DSC_ALERT);
        r_nxt.alert_relay = alerting; // [R05]
        r_nxt.alert_led   = alerting; // [R13]
        r_nxt.alert_tone  = alerting && !off_hook_s; // [R14]
        r_nxt.ringback    = alerting && !r_nxt.all_call; // [R09] [R11]

        // apb slave, one wait state
        r_nxt.ready  = psel & penable & ~r_r.ready;
        r_nxt.slverr = 1'b0;
        r_nxt.rdata  = '0;
        if (psel && penable && !r_r.ready) begin
            unique case (paddr)
                `DSC_REG_STATUS: begin
                    r_nxt.rdata = {23'h0,
                                   ~len_ok,
                                   r_r.all_call,
                                   off_hook_s,
                                   r_r.dig_cnt,
                                   1'b0,
                                   r_r.st};
                end
                `DSC_REG_CTRL:       r_nxt.rdata = {30'h0, r_r.ctrl};
                `DSC_REG_IRQ_STAT:   r_nxt.rdata = {27'h0, r_r.irq_stat};
                `DSC_REG_IRQ_CLR:    r_nxt.rdata = '0;
                `DSC_REG_IRQ_EN:     r_nxt.rdata = {27'h0, r_r.irq_en};
                `DSC_REG_LAST_DIGIT: r_nxt.rdata = {28'h0, r_r.last_digit};
                default:             r_nxt.slverr = 1'b1;
            endcase
        end
        if (apb_rd) begin
            r_nxt.rdata = '0;
        end
        if (apb_wr) begin
            unique case (paddr)
                `DSC_REG_CTRL:    r_nxt.ctrl   = pwdata[1:0];
                `DSC_REG_IRQ_CLR: clr          = pwdata[`DSC_IRQ_W-1:0];
                `DSC_REG_IRQ_EN:  r_nxt.irq_en = pwdata[`DSC_IRQ_W-1:0];
                default: ;
            endcase
        end

        // sticky status, set wins over clear
        r_nxt.irq_stat = (r_r.irq_stat & ~clr) | ev;
        r_nxt.irq      = |(r_nxt.irq_stat & r_nxt.irq_en);
    end

    //////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_r       <= '0;
            r_r.st    <= dsc_pkg::DSC_COLLECT;
            r_r.ctrl  <= `DSC_CTRL_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata              = r_r.rdata;
    assign pready              = r_r.ready;
    assign pslverr             = r_r.slverr;
    assign off_hook_keying_out = r_r.keying;
    assign call_alert_out      = r_r.alert_relay;
    assign off_hook_led_out    = r_r.off_led;
    assign speaker_mute_out    = r_r.mute;
    assign alert_led_out       = r_r.alert_led;
    assign alert_tone_out      = r_r.alert_tone;
    assign ringback_out        = r_r.ringback;
    assign irq_out             = r_r.irq;
endmodule

// File: dsc_decoder_sva.sv
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_decoder_sva #(
    parameter int RING_CYCLES    = `DSC_RING_CYCLES,
    parameter int ALLCALL_CYCLES = `DSC_ALLCALL_CYCLES
) (
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       tone_valid_in,
    input  wire logic [3:0] tone_code_in,
    input  wire logic       hook_off_in,
    input  wire logic       headset_in,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pready,
    input  wire logic       off_hook_keying_out,
    input  wire logic       call_alert_out,
    input  wire logic       off_hook_led_out,
    input  wire logic       speaker_mute_out,
    input  wire logic       alert_led_out,
    input  wire logic       alert_tone_out,
    input  wire logic       ringback_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic   off_w = hook_off_in | headset_in;
    logic        tv_q;
    logic [31:0] ring_r;
    logic [31:0] star_r;
    ////////////////////////////////////////
    // alert length and star hold counters
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tv_q   <= 1'b0;
            ring_r <= '0;
            star_r <= '0;
        end else begin
            tv_q   <= tone_valid_in;
            ring_r <= call_alert_out ? ring_r + 32'h1 : 32'h0;
            if (tone_valid_in)
                star_r <= (tone_code_in != `DSC_CODE_STAR) ? 32'h0
                        : (tv_q ? star_r + 32'h1 : 32'h1);
        end
    end
    ////////////////////////////////////////
    a_keying_follows: assert property (off_w [*4] |-> off_hook_keying_out)
        else $error("keying relay off while off hook");
    a_keying_drops: assert property (!off_w [*4] |-> !off_hook_keying_out)
        else $error("keying relay on while on hook");
    a_led_mute_pair: assert property (
        off_hook_led_out == off_hook_keying_out && speaker_mute_out == off_hook_keying_out)
        else $error("hook indicator or mute differs from keying");
    a_relay_led_pair: assert property (call_alert_out == alert_led_out)
        else $error("alert indicator differs from alert relay");
    a_tone_on_hook: assert property (alert_tone_out |-> call_alert_out
        && !(off_hook_keying_out && $past(off_hook_keying_out)))
        else $error("alert tone while off hook or not alerting");
    a_ringback_alert: assert property (ringback_out |-> call_alert_out)
        else $error("ringback without alert");
    a_answer_stops: assert property (off_w [*6] |-> !call_alert_out)
        else $error("alert kept while off hook");
    a_ring_bound: assert property (ring_r <= RING_CYCLES + 4)
        else $error("alert outlasts ring period");
    a_allcall_hold: assert property (
        $rose(call_alert_out) && !ringback_out |-> star_r >= ALLCALL_CYCLES)
        else $error("all-call alert without long star");
    a_apb_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("apb answer not after one wait state");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    c_match: cover property ($rose(call_alert_out) && ringback_out);
    c_allcall: cover property ($rose(call_alert_out) && !ringback_out);
    c_timeout: cover property ($fell(call_alert_out) && !off_w);
    c_answer: cover property ($fell(call_alert_out) && off_w);
endmodule

bind dsc_decoder dsc_decoder_sva #(
    .RING_CYCLES(RING_CYCLES), .ALLCALL_CYCLES(ALLCALL_CYCLES)
) u_sva (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .tone_valid_in(tone_valid_in),
    .tone_code_in(tone_code_in), .hook_off_in(hook_off_in), .headset_in(headset_in),
    .psel(psel), .penable(penable), .pready(pready),
    .off_hook_keying_out(off_hook_keying_out), .call_alert_out(call_alert_out),
    .off_hook_led_out(off_hook_led_out), .speaker_mute_out(speaker_mute_out),
    .alert_led_out(alert_led_out), .alert_tone_out(alert_tone_out),
    .ringback_out(ringback_out)
);

// File: dsc_line_model.sv
`timescale 1ns/1ps
module dsc_line_model (
    input  wire logic       ref_clk_in,
    output logic            tone_valid_out,
    output logic      [3:0] tone_code_out
);
    initial begin
        tone_valid_out = 1'b0;
        tone_code_out  = 4'h0;
    end
    ////////////////////////////////////////
    // one tone burst, code wanders in the gap
    task automatic tone(input logic [3:0] code, input int hold);
        @(posedge ref_clk_in);
        tone_code_out  <= code;
        tone_valid_out <= 1'b1;
        repeat (hold) @(posedge ref_clk_in);
        tone_valid_out <= 1'b0;
        repeat (6) begin
            @(posedge ref_clk_in);
            tone_code_out <= ~tone_code_out;
        end
    endtask
endmodule

// File: dsc_decoder_test.sv
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_decoder_test;
    localparam int RING = 200;
    localparam int ALLC = 50;
    logic        clk;
    logic        rst;
    logic        tv;
    logic        hook;
    logic        head;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        ex;
    logic [3:0]  tc;
    logic [3:0]  len;
    logic [15:0] sw;
    logic [15:0] own;
    logic [15:0] rx;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    wire  [7:0]  o;
    int          n;
    int          fails;
    int          num_checks;
    int          seed;
    dsc_line_model u_line (.ref_clk_in(clk), .tone_valid_out(tv), .tone_code_out(tc));
    dsc_decoder #(.RING_CYCLES(RING), .ALLCALL_CYCLES(ALLC)) dut (
        .ref_clk_in(clk), .sys_rst_in(rst), .tone_valid_in(tv), .tone_code_in(tc),
        .address_length_select_in(len), .first_digit_select_in(sw[3:0]),
        .second_digit_select_in(sw[7:4]), .third_digit_select_in(sw[11:8]),
        .fourth_digit_select_in(sw[15:12]), .hook_off_in(hook), .headset_in(head),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .off_hook_keying_out(o[0]), .call_alert_out(o[1]), .off_hook_led_out(o[2]),
        .speaker_mute_out(o[3]), .alert_led_out(o[4]), .alert_tone_out(o[5]),
        .ringback_out(o[6]), .irq_out(o[7]));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setup(input logic [15:0] a, input int k);
        @(posedge clk);
        sw  <= a;
        len <= 4'h1 << (k - 1);
        repeat (4) @(posedge clk);
    endtask
    task automatic dial(input logic [15:0] a, input int k);
        for (int i = 0; i < k; i++)
            u_line.tone(a[4*i+:4], 4 + $unsigned($random(seed)) % 3);
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [15:0] rnd_addr();
        logic [15:0] a;
        a = $random(seed);
        for (int i = 0; i < 4; i++)
            if (a[4*i+:4] == `DSC_CODE_STAR || a[4*i+:4] == `DSC_CODE_HASH)
                a[4*i+:4] ^= 4'h8;
        return a;
    endfunction
    function automatic logic hit(logic [15:0] r, logic [15:0] a, int k);
        for (int i = 0; i < k; i++)
            if (r[4*i+:4] != a[4*i+:4] && r[4*i+:4] != `DSC_CODE_STAR)
                return 1'b0;
        return 1'b1;
    endfunction
    function automatic logic [6:0] outs(logic al, logic rb, logic off);
        return {rb, al & !off, al, off, off, al, off};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
    initial begin
        {rst, len} = {1'b1, 4'h1};
        {hook, head, psel, penable, pwrite, paddr, pwdata, sw} = '0;
        {seed, fails, num_checks} = {32'd10, 32'd0, 32'd0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(o, 8'h00);
        apb(1'b0, `DSC_REG_CTRL, 0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h020, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `DSC_REG_CTRL, 32'h0);
        apb(1'b0, `DSC_REG_CTRL, 0);
        chk(rd, 32'h0);
        apb(1'b1, `DSC_REG_CTRL, 32'h3);
        apb(1'b1, `DSC_REG_IRQ_EN, 32'h1f);
        $display("test registers done");
        own = rnd_addr();
        own[7:4] = (own[3:0] == 4'h1) ? 4'h2 : 4'h1;
        setup(own, 2);
        u_line.tone(own[3:0], 4);
        u_line.tone(`DSC_CODE_HASH, 4);
        dial(own, 2);
        chk(o[6:0], outs(1, 1, 0));
        repeat (RING - 30) @(posedge clk);
        chk(o[1], 1'b1);
        repeat (40) @(posedge clk);
        chk(o[6:0], 0);
        apb(1'b0, `DSC_REG_IRQ_STAT, 0);
        chk(rd, 32'h15);
        chk(o[7], 1'b1);
        apb(1'b1, `DSC_REG_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk(o[7], 1'b0);
        apb(1'b1, `DSC_REG_IRQ_CLR, 32'h1f);
        apb(1'b0, `DSC_REG_IRQ_STAT, 0);
        chk(rd, 32'h0);
        apb(1'b1, `DSC_REG_IRQ_EN, 32'h1f);
        $display("test clear and timeout done");
        for (int t = 0; t < 12; t++) begin
            n   = 1 + $unsigned($random(seed)) % 4;
            own = rnd_addr();
            rx  = own;
            if (t % 3 == 1)
                rx[4*(n-1)+:4] = (own[4*(n-1)+:4] == 4'h1) ? 4'h2 : 4'h1;
            if (t % 3 == 2)
                rx[4*(t%n)+:4] = `DSC_CODE_STAR;
            setup(own, n);
            dial(rx, n);
            ex = hit(rx, own, n);
            chk(o[6:0], outs(ex, ex, 0));
            apb(1'b0, `DSC_REG_LAST_DIGIT, 0);
            chk(rd, {28'h0, rx[4*(n-1)+:4]});
            hook <= 1'b1;
            repeat (6) @(posedge clk);
            chk(o[6:0], outs(0, 0, 1));
            hook <= 1'b0;
            repeat (6) @(posedge clk);
            chk(o[6:0], 0);
        end
        $display("test random addresses done");
        u_line.tone(`DSC_CODE_STAR, ALLC + 10);
        repeat (2) @(posedge clk);
        chk(o[6:0], outs(1, 0, 0));
        hook <= 1'b1;
        repeat (6) @(posedge clk);
        u_line.tone(`DSC_CODE_STAR, ALLC + 10);
        chk(o[6:0], outs(0, 0, 1));
        hook <= 1'b0;
        head <= 1'b1;
        setup(own, n);
        dial(own, n);
        chk(o[6:0], outs(0, 0, 1));
        head <= 1'b0;
        repeat (6) @(posedge clk);
        len <= 4'h3;
        repeat (4) @(posedge clk);
        dial(own, 1);
        chk(o[6:0], 0);
        apb(1'b0, `DSC_REG_STATUS, 0);
        chk(rd, 32'h181);
        $display("test all-call and headset done");
        summarize();
    end
endmodule
